// ==== rtl/cpwm_core.sv ====
// Triangle counter, compare buffering, dead time and forced duty for one pin pair.
// Assumes register values arrive from the bus slave on the same clock.
`timescale 1ns/1ps
module cpwm_core #(
	parameter int CNT_W = 16
) (
	input wire logic mclk_i,
	input wire logic rst_i,
	cpwm_ctl_if.core ctl,
	output logic pos_phase_pin_o,
	output logic neg_phase_pin_o
);
	cpwm_pkg::cnt_dir_t dir_q;
	logic [CNT_W-1:0] cnt_q, pos_cmp_q, neg_cmp_q, pos_eff;
	logic [1:0] fsel_q [2];
	logic [1:0] fsel_wr [2];
	logic rec_wr [2];
	logic [1:0] fn_wr [2];
	logic [1:0] pin_q;
	logic [1:0] raw;
	logic [1:0] forced;
	logic trough, crest, at_top, at_bot, load_crest;
	logic pos_match, neg_match, corr;
	assign at_top = cnt_q >= ctl.period[CNT_W-1:0];
	assign at_bot = cnt_q == '0;
	assign trough = ctl.run && dir_q == cpwm_pkg::CNT_DOWN && at_bot;
	assign crest = ctl.run && dir_q == cpwm_pkg::CNT_UP && at_top;
	// Mode 1 reloads at the trough only; modes 0, 2 and 3 also reload at the crest.
	assign load_crest = crest && ctl.mode != cpwm_pkg::MODE_1;
	// A positive value under the dead time cannot fit; it is corrected to dead+1.
	assign corr = ctl.dte && pos_cmp_q < ctl.dead[CNT_W-1:0];
	assign pos_eff = corr ? ctl.dead[CNT_W-1:0] + CNT_W'(1) : pos_cmp_q;
	assign pos_match = cnt_q == pos_eff;
	// With dead time on, the negative compare point sits the dead time below the positive compare point.
	assign neg_match = ctl.dte ? cnt_q == pos_eff - ctl.dead[CNT_W-1:0]
		: cnt_q == neg_cmp_q;
	// Raw complementary levels: positive active while counter is at or above compare.
	assign raw[0] = cnt_q >= pos_eff;
	assign raw[1] = ctl.dte ? (cnt_q < pos_eff - ctl.dead[CNT_W-1:0] || corr && at_bot)
		: cnt_q < neg_cmp_q;
	assign ctl.pos_cmp = pos_cmp_q;
	assign ctl.neg_cmp = neg_cmp_q;
	assign ctl.status = {22'h000000, forced, pin_q, corr, dir_q == cpwm_pkg::CNT_DOWN,
		fsel_q[1], fsel_q[0]};
	assign pos_phase_pin_o = pin_q[0];
	assign neg_phase_pin_o = pin_q[1];
	always_ff @(posedge mclk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			cnt_q <= '0;
			dir_q <= cpwm_pkg::CNT_UP;
			pos_cmp_q <= '0;
			neg_cmp_q <= '0;
		end
		else if (ctl.run)
		begin
			cnt_q <= (dir_q == cpwm_pkg::CNT_UP) ? (at_top ? cnt_q - CNT_W'(1) : cnt_q + CNT_W'(1))
				: (at_bot ? cnt_q + CNT_W'(1) : cnt_q - CNT_W'(1));
			if (crest)
				dir_q <= cpwm_pkg::CNT_DOWN;
			else if (trough)
				dir_q <= cpwm_pkg::CNT_UP;
			if (trough || load_crest)
			begin
				pos_cmp_q <= ctl.pos_buf[CNT_W-1:0];
				neg_cmp_q <= ctl.neg_buf[CNT_W-1:0];
			end
		end
	end
	genvar g;
	generate
		for (g = 0; g < 2; g++)
		begin : g_pin
			logic rec_lvl;
			logic lvl_q;
			logic hold_q;
			logic [1:0] sel_q;
			logic cmp_hit;
			assign fsel_wr[g] = ctl.duty[g*4 +: 2];
			assign rec_wr[g] = ctl.duty[g*4 + 2];
			assign fn_wr[g] = ctl.pinfn[g*4 + 2 +: 2];
			assign forced[g] = sel_q[1];
			assign fsel_q[g] = sel_q;
			assign pin_q[g] = lvl_q;
			assign cmp_hit = (g == 0) ? pos_match : neg_match;
			// Recovery: bit 0 with function 00 inverts; bit 1 takes the raw level; otherwise function bit 0 picks level.
			assign rec_lvl = (!rec_wr[g] && fn_wr[g] == 2'h0) ? ~pin_q[g]
				: (rec_wr[g] ? raw[g] : fn_wr[g][0]);
			// The recovery level stands until the next compare match; without the hold the
			// raw waveform would overwrite it at the very next clock.
			always_ff @(posedge mclk_i or posedge rst_i)
			begin
				if (rst_i)
				begin
					sel_q <= cpwm_pkg::DUTY_OFF;
					lvl_q <= 1'b0;
					hold_q <= 1'b0;
				end
				else if (trough)
				begin
					sel_q <= fsel_wr[g];
					hold_q <= forced[g] && !fsel_wr[g][1];
					if (fsel_wr[g] == cpwm_pkg::DUTY_100)
						lvl_q <= 1'b1;
					else if (fsel_wr[g] == cpwm_pkg::DUTY_0)
						lvl_q <= 1'b0;
					else if (forced[g])
						lvl_q <= rec_lvl;
					else
						lvl_q <= raw[g];
				end
				else if (!forced[g] && ctl.run)
				begin
					if (cmp_hit)
						hold_q <= 1'b0;
					if (cmp_hit || (!hold_q && lvl_q != raw[g]))
						lvl_q <= raw[g];
				end
				else
					lvl_q <= lvl_q;
			end
		end
	endgenerate
endmodule

// ==== rtl/cpwm_ctl_if.sv ====
// Interface carrying the register contents from the bus slave to the core.
// Assumes both ends share one clock.
`timescale 1ns/1ps
interface cpwm_ctl_if;
	logic run;
	logic dte;
	logic [1:0] mode;
	logic [15:0] period;
	logic [15:0] pos_buf;
	logic [15:0] neg_buf;
	logic [15:0] dead;
	logic [7:0] duty;
	logic [7:0] pinfn;
	logic [31:0] status;
	logic [15:0] pos_cmp;
	logic [15:0] neg_cmp;
	modport regs (output run, dte, mode, period, pos_buf, neg_buf, dead, duty, pinfn,
		input status, pos_cmp, neg_cmp);
	modport core (input run, dte, mode, period, pos_buf, neg_buf, dead, duty, pinfn,
		output status, pos_cmp, neg_cmp);
endinterface

// ==== rtl/cpwm_pkg.sv ====
// Package for the complementary PWM channel with forced duty control.
// Assumes a single 25 MHz clock domain and an AXI4-Lite register bus.
package cpwm_pkg;
	localparam int CNT_W = 16;
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_PERIOD = 8'h04;
	localparam logic [7:0] OFS_POS_BUF = 8'h08;
	localparam logic [7:0] OFS_NEG_BUF = 8'h0C;
	localparam logic [7:0] OFS_DEAD = 8'h10;
	localparam logic [7:0] OFS_DUTY = 8'h14;
	localparam logic [7:0] OFS_PINFN = 8'h18;
	localparam logic [7:0] OFS_STATUS = 8'h1C;
	localparam logic [7:0] OFS_POS_CMP = 8'h20;
	localparam logic [7:0] OFS_NEG_CMP = 8'h24;
	localparam int CTRL_RUN = 0;
	localparam int CTRL_DTE = 1;
	localparam int CTRL_MODE_LO = 2;
	localparam int DUTY_A_LO = 0;
	localparam int DUTY_A_REC = 2;
	localparam int DUTY_B_LO = 4;
	localparam int DUTY_B_REC = 6;
	localparam int PINFN_A_LO = 0;
	localparam int PINFN_B_LO = 4;
	localparam logic [1:0] DUTY_OFF = 2'h0;
	localparam logic [1:0] DUTY_0 = 2'h2;
	localparam logic [1:0] DUTY_100 = 2'h3;
	localparam logic [1:0] MODE_1 = 2'h1;
	localparam logic [1:0] MODE_2 = 2'h2;
	localparam logic [1:0] MODE_3 = 2'h3;
	localparam logic [15:0] PERIOD_RST = 16'h00FF;
	localparam logic [15:0] DEAD_RST = 16'h0004;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef enum logic [1:0] {CNT_UP = 2'b00, CNT_DOWN = 2'b01} cnt_dir_t;
endpackage

// ==== rtl/cpwm_regs.sv ====
// AXI4-Lite register slave for the complementary PWM channel.
// Assumes a master that keeps at most one write and one read outstanding.
//
// The AXI4-Lite slave port and the address map are this design's own decisions.
`timescale 1ns/1ps
module cpwm_regs (
	input wire logic mclk_i,
	input wire logic rst_i,
	input wire logic [7:0] awaddr_i,
	input wire logic awvalid_i,
	output logic awready_o,
	input wire logic [31:0] wdata_i,
	input wire logic [3:0] wstrb_i,
	input wire logic wvalid_i,
	output logic wready_o,
	output logic [1:0] bresp_o,
	output logic bvalid_o,
	input wire logic bready_i,
	input wire logic [7:0] araddr_i,
	input wire logic arvalid_i,
	output logic arready_o,
	output logic [31:0] rdata_o,
	output logic [1:0] rresp_o,
	output logic rvalid_o,
	input wire logic rready_i,
	cpwm_ctl_if.regs ctl
);
	logic aw_q, w_q, bvalid_q, rvalid_q;
	logic [7:0] awa_q;
	logic [31:0] wd_q, rdata_q;
	logic [3:0] ws_q;
	logic [1:0] bresp_q, rresp_q;
	logic [31:0] ctrl_q, period_q, posb_q, negb_q, dead_q, duty_q, pinfn_q;
	logic [31:0] wmask, rmux;
	logic wr_go, rd_go, wr_hit, rd_hit;
	assign awready_o = !aw_q && !bvalid_q;
	assign wready_o = !w_q && !bvalid_q;
	assign arready_o = !rvalid_q;
	assign bvalid_o = bvalid_q;
	assign bresp_o = bresp_q;
	assign rvalid_o = rvalid_q;
	assign rdata_o = rdata_q;
	assign rresp_o = rresp_q;
	assign wr_go = aw_q && w_q && !bvalid_q;
	assign rd_go = arvalid_i && !rvalid_q;
	assign wmask = {{8{ws_q[3]}}, {8{ws_q[2]}}, {8{ws_q[1]}}, {8{ws_q[0]}}};
	assign wr_hit = awa_q <= cpwm_pkg::OFS_PINFN && awa_q[1:0] == 2'h0;
	assign rd_hit = araddr_i <= cpwm_pkg::OFS_NEG_CMP && araddr_i[1:0] == 2'h0;
	always_comb
	begin
		unique case (araddr_i)
			cpwm_pkg::OFS_CTRL: rmux = ctrl_q & 32'h0000000F;
			cpwm_pkg::OFS_PERIOD: rmux = period_q & 32'h0000FFFF;
			cpwm_pkg::OFS_POS_BUF: rmux = posb_q & 32'h0000FFFF;
			cpwm_pkg::OFS_NEG_BUF: rmux = negb_q & 32'h0000FFFF;
			cpwm_pkg::OFS_DEAD: rmux = dead_q & 32'h0000FFFF;
			cpwm_pkg::OFS_DUTY: rmux = duty_q & 32'h000000FF;
			cpwm_pkg::OFS_PINFN: rmux = pinfn_q & 32'h000000FF;
			cpwm_pkg::OFS_STATUS: rmux = ctl.status;
			cpwm_pkg::OFS_POS_CMP: rmux = {16'h0000, ctl.pos_cmp};
			cpwm_pkg::OFS_NEG_CMP: rmux = {16'h0000, ctl.neg_cmp};
			default: rmux = 32'h00000000;
		endcase
	end
	assign ctl.run = ctrl_q[cpwm_pkg::CTRL_RUN];
	assign ctl.dte = ctrl_q[cpwm_pkg::CTRL_DTE];
	assign ctl.mode = ctrl_q[cpwm_pkg::CTRL_MODE_LO +: 2];
	assign ctl.period = period_q[15:0];
	assign ctl.pos_buf = posb_q[15:0];
	assign ctl.neg_buf = negb_q[15:0];
	assign ctl.dead = dead_q[15:0];
	assign ctl.duty = duty_q[7:0];
	assign ctl.pinfn = pinfn_q[7:0];
	always_ff @(posedge mclk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			aw_q <= 1'b0;
			w_q <= 1'b0;
			awa_q <= 8'h00;
			wd_q <= 32'h00000000;
			ws_q <= 4'h0;
			bvalid_q <= 1'b0;
			bresp_q <= 2'h0;
		end
		else
		begin
			if (awvalid_i && awready_o)
			begin
				aw_q <= 1'b1;
				awa_q <= awaddr_i;
			end
			if (wvalid_i && wready_o)
			begin
				w_q <= 1'b1;
				wd_q <= wdata_i;
				ws_q <= wstrb_i;
			end
			if (wr_go)
			begin
				aw_q <= 1'b0;
				w_q <= 1'b0;
				bvalid_q <= 1'b1;
				bresp_q <= wr_hit ? cpwm_pkg::RESP_OKAY : cpwm_pkg::RESP_SLVERR;
			end
			else if (bvalid_q && bready_i)
				bvalid_q <= 1'b0;
		end
	end
	always_ff @(posedge mclk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			ctrl_q <= 32'h00000004;
			period_q <= {16'h0000, cpwm_pkg::PERIOD_RST};
			posb_q <= 32'h00000000;
			negb_q <= 32'h00000000;
			dead_q <= {16'h0000, cpwm_pkg::DEAD_RST};
			duty_q <= 32'h00000000;
			pinfn_q <= 32'h00000000;
		end
		else if (wr_go && wr_hit)
		begin
			unique case (awa_q)
				cpwm_pkg::OFS_CTRL: ctrl_q <= (ctrl_q & ~wmask) | (wd_q & wmask);
				cpwm_pkg::OFS_PERIOD: period_q <= (period_q & ~wmask) | (wd_q & wmask);
				cpwm_pkg::OFS_POS_BUF: posb_q <= (posb_q & ~wmask) | (wd_q & wmask);
				cpwm_pkg::OFS_NEG_BUF: negb_q <= (negb_q & ~wmask) | (wd_q & wmask);
				cpwm_pkg::OFS_DEAD: dead_q <= (dead_q & ~wmask) | (wd_q & wmask);
				cpwm_pkg::OFS_DUTY: duty_q <= (duty_q & ~wmask) | (wd_q & wmask);
				cpwm_pkg::OFS_PINFN: pinfn_q <= (pinfn_q & ~wmask) | (wd_q & wmask);
				default: ctrl_q <= ctrl_q;
			endcase
		end
	end
	always_ff @(posedge mclk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			rvalid_q <= 1'b0;
			rdata_q <= 32'h00000000;
			rresp_q <= 2'h0;
		end
		else if (rd_go)
		begin
			rvalid_q <= 1'b1;
			rdata_q <= rmux;
			rresp_q <= rd_hit ? cpwm_pkg::RESP_OKAY : cpwm_pkg::RESP_SLVERR;
		end
		else if (rvalid_q && rready_i)
			rvalid_q <= 1'b0;
	end
endmodule

// ==== rtl/cpwm_top.sv ====
// Complementary triangle-wave PWM channel with forced 0%/100% duty control.
// Assumes one 25 MHz clock; pins drive external gate drivers directly.
`timescale 1ns/1ps
module cpwm_top #(
	parameter int CNT_W = cpwm_pkg::CNT_W
) (
	input wire logic mclk_i,
	input wire logic rst_i,
	input wire logic [7:0] awaddr_i,
	input wire logic awvalid_i,
	output logic awready_o,
	input wire logic [31:0] wdata_i,
	input wire logic [3:0] wstrb_i,
	input wire logic wvalid_i,
	output logic wready_o,
	output logic [1:0] bresp_o,
	output logic bvalid_o,
	input wire logic bready_i,
	input wire logic [7:0] araddr_i,
	input wire logic arvalid_i,
	output logic arready_o,
	output logic [31:0] rdata_o,
	output logic [1:0] rresp_o,
	output logic rvalid_o,
	input wire logic rready_i,
	output logic pos_phase_pin_o,
	output logic neg_phase_pin_o
);
	cpwm_ctl_if ctl ();
	cpwm_regs u_regs (
		.mclk_i(mclk_i),
		.rst_i(rst_i),
		.awaddr_i(awaddr_i),
		.awvalid_i(awvalid_i),
		.awready_o(awready_o),
		.wdata_i(wdata_i),
		.wstrb_i(wstrb_i),
		.wvalid_i(wvalid_i),
		.wready_o(wready_o),
		.bresp_o(bresp_o),
		.bvalid_o(bvalid_o),
		.bready_i(bready_i),
		.araddr_i(araddr_i),
		.arvalid_i(arvalid_i),
		.arready_o(arready_o),
		.rdata_o(rdata_o),
		.rresp_o(rresp_o),
		.rvalid_o(rvalid_o),
		.rready_i(rready_i),
		.ctl(ctl)
	);
	cpwm_core #(.CNT_W(CNT_W)) u_core (
		.mclk_i(mclk_i),
		.rst_i(rst_i),
		.ctl(ctl),
		.pos_phase_pin_o(pos_phase_pin_o),
		.neg_phase_pin_o(neg_phase_pin_o)
	);
endmodule

// ==== verif/cpwm_assertions.sv ====
// Concurrent checks on the complementary PWM top ports.
// Assumes the bench sets a short period before any forced duty write.
`timescale 1ns/1ps
module cpwm_checker (
	input wire logic mclk_i,
	input wire logic rst_i,
	input wire logic [7:0] awaddr_i,
	input wire logic awvalid_i,
	input wire logic awready_o,
	input wire logic [31:0] wdata_i,
	input wire logic wvalid_i,
	input wire logic wready_o,
	input wire logic [1:0] bresp_o,
	input wire logic bvalid_o,
	input wire logic bready_i,
	input wire logic arvalid_i,
	input wire logic arready_o,
	input wire logic [31:0] rdata_o,
	input wire logic rvalid_o,
	input wire logic rready_i,
	input wire logic pos_phase_pin_o,
	input wire logic neg_phase_pin_o
);
	// A forced code waits for a trough, so one short triangle bounds the delay.
	localparam int TROUGH_MAX = 40;
	wire logic wr_both = awvalid_i && awready_o && wvalid_i && wready_o;
	wire logic wr_duty = wr_both && awaddr_i == cpwm_pkg::OFS_DUTY;
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (rst_i);
	a_bresp_held: assert property (bvalid_o && !bready_i |=> bvalid_o && $stable(bresp_o))
		else $error("Write response changed before it was accepted.");
	a_rdata_held: assert property (rvalid_o && !rready_i |=> rvalid_o && $stable(rdata_o))
		else $error("Read data changed before it was accepted.");
	a_write_answer: assert property (wr_both |-> ##2 bvalid_o)
		else $error("No write response two cycles after address and data.");
	a_read_answer: assert property (arvalid_i && arready_o |=> rvalid_o)
		else $error("No read data one cycle after the read address.");
	a_read_refused: assert property (rvalid_o |-> !arready_o)
		else $error("Read address accepted while read data pending.");
	a_write_refused: assert property (bvalid_o |-> !awready_o && !wready_o)
		else $error("Write accepted while write response pending.");
	a_force_high: assert property (wr_duty && wdata_i[1:0] == 2'h3 |-> ##[1:TROUGH_MAX] pos_phase_pin_o)
		else $error("Positive pin not forced high by the next trough.");
	a_force_low: assert property (wr_duty && wdata_i[5:4] == 2'h2 |-> ##[1:TROUGH_MAX] !neg_phase_pin_o)
		else $error("Negative pin not forced low by the next trough.");
endmodule

// ==== verif/gate_driver_model.sv ====
// Gate driver stand-in that measures how long the negative switch is held on.
// Assumes the pins are registered on the same clock as the bench.
`timescale 1ns/1ps
module gate_driver_model (
	input wire logic mclk_i,
	input wire logic rst_i,
	input wire logic neg_phase_pin_i,
	output int neg_width_o
);
	// A real bridge would fault on overlap; this one only records widths for the bench.
	int run_q;
	always_ff @(posedge mclk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			run_q <= 0;
			neg_width_o <= 0;
		end
		else if (neg_phase_pin_i)
			run_q <= run_q + 1;
		else if (run_q != 0)
		begin
			neg_width_o <= run_q;
			run_q <= 0;
		end
	end
endmodule

// ==== verif/test_complementary_pwm_forced_duty.sv ====
// Self-checking bench for the complementary PWM channel with forced duty.
// Assumes the package, the top module, the checker and the driver model compile first.
`timescale 1ns/1ps
module test_complementary_pwm_forced_duty;
	localparam int P = 16;
	logic mclk_i = 1'b0;
	logic rst_i = 1'b1;
	logic [7:0] awaddr_i = 8'h00;
	logic awvalid_i = 1'b0;
	logic [31:0] wdata_i = 32'h0;
	logic [3:0] wstrb_i = 4'hF;
	logic wvalid_i = 1'b0;
	logic bready_i = 1'b0;
	logic [7:0] araddr_i = 8'h00;
	logic arvalid_i = 1'b0;
	logic rready_i = 1'b0;
	logic awready_o, wready_o, bvalid_o, arready_o, rvalid_o, pos_phase_pin_o, neg_phase_pin_o;
	logic [1:0] bresp_o, rresp_o, rr;
	logic [31:0] rdata_o, rd;
	int neg_width;
	int w6;
	int num_errors = 0;
	int check_count = 0;
	always #20 mclk_i = ~mclk_i;
	cpwm_top dut (.mclk_i, .rst_i, .awaddr_i, .awvalid_i, .awready_o, .wdata_i, .wstrb_i, .wvalid_i,
		.wready_o, .bresp_o, .bvalid_o, .bready_i, .araddr_i, .arvalid_i, .arready_o, .rdata_o,
		.rresp_o, .rvalid_o, .rready_i, .pos_phase_pin_o, .neg_phase_pin_o);
	gate_driver_model gdm (.mclk_i, .rst_i, .neg_phase_pin_i(neg_phase_pin_o), .neg_width_o(neg_width));
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e)
		begin
			$display("[ERR] %s expected %h seen %h", nm, e, g);
			num_errors++;
		end
	endtask
	task cyc(input int n);
		repeat (n) @(posedge mclk_i);
	endtask
	// Handshakes are judged at the falling edge, so no decision races the rising edge.
	task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		logic aw, w, b;
		b = 1'b0;
		@(posedge mclk_i);
		awaddr_i <= a;
		wdata_i <= d;
		awvalid_i <= 1'b1;
		wvalid_i <= 1'b1;
		bready_i <= 1'b1;
		for (int n = 0; n < 50 && !b; n++)
		begin
			@(negedge mclk_i);
			aw = awvalid_i && awready_o;
			w = wvalid_i && wready_o;
			b = bvalid_o;
			rr = bresp_o;
			@(posedge mclk_i);
			if (aw)
				awvalid_i <= 1'b0;
			if (w)
				wvalid_i <= 1'b0;
		end
		bready_i <= 1'b0;
		chk("write answered", 32'h1, {31'h0, b});
		chk("write response", {30'h0, er}, {30'h0, rr});
	endtask
	task rdr(input logic [7:0] a, input logic [1:0] er, input logic [31:0] ed);
		logic ar, r;
		r = 1'b0;
		@(posedge mclk_i);
		araddr_i <= a;
		arvalid_i <= 1'b1;
		rready_i <= 1'b1;
		for (int n = 0; n < 50 && !r; n++)
		begin
			@(negedge mclk_i);
			ar = arvalid_i && arready_o;
			r = rvalid_o;
			rd = rdata_o;
			rr = rresp_o;
			@(posedge mclk_i);
			if (ar)
				arvalid_i <= 1'b0;
		end
		rready_i <= 1'b0;
		chk("read answered", 32'h1, {31'h0, r});
		chk("read response", {30'h0, er}, {30'h0, rr});
		chk("read data", ed, rd);
	endtask
	task pins(input logic p, input logic q, input int n);
		repeat (n)
		begin
			@(negedge mclk_i);
			chk("pin pair", {30'h0, p, q}, {30'h0, pos_phase_pin_o, neg_phase_pin_o});
		end
	endtask
	task wait_pos(input logic lvl);
		int n;
		n = 0;
		do
		begin
			@(negedge mclk_i);
			n++;
		end
		while (pos_phase_pin_o !== lvl && n < 3 * P);
		chk("positive pin", {31'h0, lvl}, {31'h0, pos_phase_pin_o});
	endtask
	task s_regs;
		rdr(cpwm_pkg::OFS_CTRL, cpwm_pkg::RESP_OKAY, 32'h4);
		rdr(cpwm_pkg::OFS_PERIOD, cpwm_pkg::RESP_OKAY, {16'h0, cpwm_pkg::PERIOD_RST});
		rdr(cpwm_pkg::OFS_DEAD, cpwm_pkg::RESP_OKAY, {16'h0, cpwm_pkg::DEAD_RST});
		rdr(8'h40, cpwm_pkg::RESP_SLVERR, 32'h0);
		wr(cpwm_pkg::OFS_STATUS, 32'h0, cpwm_pkg::RESP_SLVERR);
	endtask
	task s_cmp;
		wr(cpwm_pkg::OFS_POS_BUF, 32'h8, cpwm_pkg::RESP_OKAY);
		wr(cpwm_pkg::OFS_NEG_BUF, 32'h6, cpwm_pkg::RESP_OKAY);
		wr(cpwm_pkg::OFS_CTRL, {28'h0, cpwm_pkg::MODE_1, 2'h1}, cpwm_pkg::RESP_OKAY);
		cyc(2 * P + 4);
		rdr(cpwm_pkg::OFS_POS_CMP, cpwm_pkg::RESP_OKAY, 32'h8);
		rdr(cpwm_pkg::OFS_NEG_CMP, cpwm_pkg::RESP_OKAY, 32'h6);
	endtask
	task s_force(input logic [1:0] m);
		wr(cpwm_pkg::OFS_CTRL, {28'h0, m, 2'h3}, cpwm_pkg::RESP_OKAY);
		wr(cpwm_pkg::OFS_PINFN, 32'h04, cpwm_pkg::RESP_OKAY);
		wr(cpwm_pkg::OFS_DUTY, {26'h0, cpwm_pkg::DUTY_0, 2'h0, cpwm_pkg::DUTY_100}, 2'h0);
		cyc(2 * P + 4);
		pins(1'b1, 1'b0, 2 * P + 2);
		wr(cpwm_pkg::OFS_DUTY, {26'h0, cpwm_pkg::DUTY_100, 2'h0, cpwm_pkg::DUTY_100}, 2'h0);
		cyc(2 * P + 4);
		pins(1'b1, 1'b1, 2 * P + 2);
		wr(cpwm_pkg::OFS_DUTY, {26'h0, cpwm_pkg::DUTY_0, 2'h0, cpwm_pkg::DUTY_0}, 2'h0);
		cyc(2 * P + 4);
		pins(1'b0, 1'b0, P);
		wr(cpwm_pkg::OFS_DUTY, {30'h0, cpwm_pkg::DUTY_OFF}, cpwm_pkg::RESP_OKAY);
		wait_pos(1'b1);
		pins(1'b1, 1'b1, 3);
		wait_pos(1'b0);
	endtask
	task s_narrow;
		int n;
		wr(cpwm_pkg::OFS_POS_BUF, 32'h2, cpwm_pkg::RESP_OKAY);
		cyc(4 * P + 4);
		chk("corrected negative pulse", 32'h1, 32'(neg_width));
		n = 0;
		do
		begin
			@(negedge mclk_i);
			n++;
		end
		while (neg_phase_pin_o !== 1'b1 && n < 3 * P);
		n = 0;
		while (pos_phase_pin_o !== 1'b1 && n < 3 * P)
		begin
			@(negedge mclk_i);
			n++;
		end
		// The one-count pulse sits at the trough, so the turn-on lags it by dead plus one.
		chk("positive turn-on delay", {16'h0, cpwm_pkg::DEAD_RST} + 32'h1, 32'(n));
		wr(cpwm_pkg::OFS_CTRL, {28'h0, cpwm_pkg::MODE_1, 2'h1}, cpwm_pkg::RESP_OKAY);
		wr(cpwm_pkg::OFS_POS_BUF, 32'h8, cpwm_pkg::RESP_OKAY);
		cyc(4 * P + 4);
		w6 = neg_width;
		wr(cpwm_pkg::OFS_NEG_BUF, 32'h1, cpwm_pkg::RESP_OKAY);
		cyc(4 * P + 4);
		chk("narrower negative pulse", 32'h1, {31'h0, neg_width < w6});
	endtask
	task tally_and_finish;
		$display("Comparisons %0d, mismatches %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	initial
	begin
		cyc(3);
		rst_i <= 1'b0;
		s_regs;
		wr(cpwm_pkg::OFS_PERIOD, P, cpwm_pkg::RESP_OKAY);
		s_cmp;
		s_force(cpwm_pkg::MODE_1);
		s_force(cpwm_pkg::MODE_2);
		s_force(cpwm_pkg::MODE_3);
		s_narrow;
		tally_and_finish;
	end
	initial
	begin
		cyc(20000);
		num_errors++;
		tally_and_finish;
	end
endmodule
bind cpwm_top cpwm_checker chk_i (.mclk_i, .rst_i, .awaddr_i, .awvalid_i, .awready_o, .wdata_i,
	.wvalid_i, .wready_o, .bresp_o, .bvalid_o, .bready_i, .arvalid_i, .arready_o, .rdata_o,
	.rvalid_o, .rready_i, .pos_phase_pin_o, .neg_phase_pin_o);
